// File: verilog/mcce_pkg.sv
package mcce_pkg;

    // ----------------------------------------------------------------
    // request field encodings
    // ----------------------------------------------------------------
    localparam logic [3:0] REQ_GENERIC_ERR  = 4'h0;
    localparam logic [3:0] REQ_GENERIC_RD   = 4'h1;
    localparam logic [3:0] REQ_GENERIC_WR   = 4'h2;
    localparam logic [3:0] REQ_DATA_READ    = 4'h3;
    localparam logic [3:0] REQ_DATA_WRITE   = 4'h4;
    localparam logic [3:0] REQ_INSTR_FETCH  = 4'h5;
    localparam logic [3:0] REQ_PREFETCH     = 4'h6;
    localparam logic [3:0] REQ_EVICTION     = 4'h7;
    localparam logic [3:0] REQ_SNOOP        = 4'h8;

    // ----------------------------------------------------------------
    // bus / interconnect sub-fields
    // ----------------------------------------------------------------
    localparam logic [1:0] PART_ORIGINATOR  = 2'h0;
    localparam logic [1:0] PART_ANSWERING   = 2'h1;
    localparam logic [1:0] PART_WATCHER     = 2'h2;
    localparam logic [1:0] PART_GENERIC     = 2'h3;
    localparam logic [1:0] MIO_MEMORY       = 2'h0;
    localparam logic [1:0] MIO_IO           = 2'h2;
    localparam logic [1:0] MIO_OTHER        = 2'h3;

    // ----------------------------------------------------------------
    // memory controller sub-fields
    // ----------------------------------------------------------------
    localparam logic [2:0] MTXN_UNSPEC      = 3'h0;
    localparam logic [2:0] MTXN_READ        = 3'h1;
    localparam logic [2:0] MTXN_WRITE       = 3'h2;
    localparam logic [2:0] MTXN_ADDR_CMD    = 3'h3;
    localparam logic [2:0] MTXN_SCRUB       = 3'h4;
    localparam logic [3:0] CHAN_MAX         = 4'hE;
    localparam logic [3:0] CHAN_NONE        = 4'hF;

    // ----------------------------------------------------------------
    // transaction class and level
    // ----------------------------------------------------------------
    localparam logic [1:0] TCLS_INSTR       = 2'h0;
    localparam logic [1:0] TCLS_DATA        = 2'h1;
    localparam logic [1:0] TCLS_GENERIC     = 2'h2;
    localparam logic [1:0] LVL_0            = 2'h0;
    localparam logic [1:0] LVL_2            = 2'h2;
    localparam logic [1:0] LVL_GENERIC      = 2'h3;

    // ----------------------------------------------------------------
    // code layout and fixed codes
    // ----------------------------------------------------------------
    localparam int         FILTER_BIT_POS   = 12;
    localparam logic [15:0] CODE_NONE       = 16'h0000;
    localparam logic [15:0] CODE_WRITEBACK  = 16'h017A;
    localparam logic [15:0] CODE_DATA_LOAD  = 16'h0134;
    localparam logic [15:0] CODE_INSTR_FTCH = 16'h0150;
    localparam logic [2:0]  MISC_MODE_PHYS  = 3'h2;
    localparam logic [2:0]  MISC_MODE_RESET = 3'h0;
    localparam logic [5:0]  MISC_LSB_RESET  = 6'h00;
    localparam logic [63:0] ADDR_RESET      = 64'h0000000000000000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        EV_BUS, EV_MEMCTL, EV_CACHE, EV_SCRUB, EV_WRITEBACK, EV_DATA_LOAD, EV_INSTR_FETCH
    } mcce_event_t;

    typedef enum logic [2:0] {
        ACT_UNKNOWN, ACT_READ, ACT_WRITE, ACT_PREFETCH, ACT_EVICT, ACT_SNOOP
    } mcce_action_t;

    typedef struct packed {
        mcce_event_t  kind;
        mcce_action_t action;
        logic         src_known;
        logic         is_instr;
        logic [1:0]   level;
        logic [1:0]   participation;
        logic         timed_out;
        logic [1:0]   space;
        logic [2:0]   mem_txn;
        logic [3:0]   channel;
        logic         chan_valid;
        logic [63:0]  phys_addr;
        logic [5:0]   addr_lsb;
    } mcce_err_t;

    typedef struct packed {
        logic        valid;
        logic        overflow;
        logic        uncorrected;
        logic        enabled;
        logic        misc_valid;
        logic        addr_valid;
        logic        ctx_corrupt;
        logic        signalling;
        logic        action_req;
        logic [15:0] arch_error_code;
    } mcce_status_t;

    typedef struct packed {
        logic [5:0] addr_lsb;
        logic [2:0] addr_mode;
    } mcce_misc_t;

endpackage

// File: verilog/mcce_request_enc.sv
`timescale 1ns/1ps
module mcce_request_enc
    import mcce_pkg::*;
(
    // what is known about the failing action
    input  wire mcce_pkg::mcce_action_t action,
    input  wire logic                   src_known,
    input  wire logic                   is_instr,
    input  wire logic                   cache_err,
    // encoded request field
    output logic [3:0]                  request_type_field
);
    always_comb begin
        case (action)
            ACT_READ: begin
                if (!src_known)
                    request_type_field = REQ_GENERIC_RD;
                else if (is_instr)
                    request_type_field = REQ_INSTR_FETCH;
                else
                    request_type_field = REQ_DATA_READ;
            end
            ACT_WRITE: begin
                // instruction stream never writes, so unknown source stays generic
                if (src_known && !is_instr)
                    request_type_field = REQ_DATA_WRITE;
                else
                    request_type_field = REQ_GENERIC_WR;
            end
            ACT_PREFETCH: request_type_field = REQ_PREFETCH;
            ACT_EVICT:    request_type_field = cache_err ? REQ_EVICTION : REQ_GENERIC_ERR;
            ACT_SNOOP:    request_type_field = cache_err ? REQ_SNOOP : REQ_GENERIC_ERR;
            default:      request_type_field = REQ_GENERIC_ERR;
        endcase
    end
endmodule

// File: verilog/mcce_code_compose.sv
`timescale 1ns/1ps
module mcce_code_compose
    import mcce_pkg::*;
(
    // error description and encoded request
    input  wire mcce_pkg::mcce_err_t err,
    input  wire logic [3:0]          request_type_field,
    // composed code
    output logic [15:0]              arch_error_code
);
    logic [1:0] space_fix;
    logic [3:0] chan_fix;
    logic [2:0] mtxn_fix;

    always_comb begin
        space_fix = (err.space == 2'h1) ? MIO_OTHER : err.space;
        chan_fix  = (err.chan_valid && err.channel <= CHAN_MAX) ? err.channel : CHAN_NONE;
        mtxn_fix  = (err.mem_txn > MTXN_SCRUB) ? MTXN_UNSPEC : err.mem_txn;
        // filter bit stays zero in every form built here
        case (err.kind)
            EV_BUS:
                arch_error_code = {4'h0, 1'b1, err.participation, err.timed_out,
                                   request_type_field, space_fix, err.level};
            EV_MEMCTL:
                arch_error_code = {8'h00, 1'b1, mtxn_fix, chan_fix};
            EV_SCRUB:
                arch_error_code = {8'h00, 1'b1, MTXN_SCRUB, chan_fix};
            EV_WRITEBACK:
                arch_error_code = CODE_WRITEBACK;
            EV_DATA_LOAD:
                arch_error_code = CODE_DATA_LOAD;
            EV_INSTR_FETCH:
                arch_error_code = CODE_INSTR_FTCH;
            EV_CACHE:
                arch_error_code = {7'h00, 1'b1, request_type_field,
                                   (err.src_known ? (err.is_instr ? TCLS_INSTR : TCLS_DATA) : TCLS_GENERIC),
                                   err.level};
            default:
                arch_error_code = CODE_NONE;
        endcase
    end
endmodule

// File: verilog/mcce_top.sv
`timescale 1ns/1ps
module mcce_top
    import mcce_pkg::*;
#(
    parameter int NUM_LP = 4
)
(
    // clock and reset
    input  wire logic                CLK_SYS,
    input  wire logic                RST,
    input  wire logic                CE,
    // error report from the detecting logic
    input  wire logic                ERR_VALID,
    input  wire mcce_pkg::mcce_err_t ERR_INFO,
    input  wire logic [NUM_LP-1:0]   ERR_AFFECTED_LP,
    input  wire logic [NUM_LP-1:0]   BANK_SHARERS,
    input  wire logic                UCR_SUPPORTED,
    // software side of the bank
    input  wire logic                BANK_CLEAR,
    input  wire logic                GLOBAL_CLEAR,
    // logged bank
    output mcce_pkg::mcce_status_t   BANK_STATUS,
    output mcce_pkg::mcce_misc_t     BANK_MISC,
    output logic [63:0]              BANK_ADDR,
    output logic [NUM_LP-1:0]        BANK_VISIBLE,
    // global check status per logical processor
    output logic [NUM_LP-1:0]        RESTART_IP_VALID,
    output logic [NUM_LP-1:0]        ERROR_IP_VALID,
    output logic [NUM_LP-1:0]        CHECK_EXCEPTION
);
    import mcce_pkg::*;

    // ----------------------------------------------------------------
    // code composition
    // ----------------------------------------------------------------
    logic [3:0]   req_field;
    logic [15:0]  code_d;
    logic         cache_err;
    logic         no_action;
    logic         act_req;
    mcce_status_t status_d;
    mcce_status_t status_q;
    mcce_misc_t   misc_q;
    logic [63:0]  addr_q;
    logic [NUM_LP-1:0] visible_q;
    logic [NUM_LP-1:0] restart_ip_valid_q;
    logic [NUM_LP-1:0] error_ip_valid_q;
    logic [NUM_LP-1:0] mce_q;

    assign cache_err = (ERR_INFO.kind == EV_CACHE) || (ERR_INFO.kind == EV_WRITEBACK);
    assign no_action = (ERR_INFO.kind == EV_SCRUB) || (ERR_INFO.kind == EV_WRITEBACK);
    assign act_req   = (ERR_INFO.kind == EV_DATA_LOAD) || (ERR_INFO.kind == EV_INSTR_FETCH);

    mcce_request_enc u_req (
        .action             (ERR_INFO.action),
        .src_known          (ERR_INFO.src_known),
        .is_instr           (ERR_INFO.is_instr),
        .cache_err          (cache_err),
        .request_type_field (req_field)
    );

    mcce_code_compose u_code (
        .err                (ERR_INFO),
        .request_type_field (req_field),
        .arch_error_code    (code_d)
    );

    // ----------------------------------------------------------------
    // status flag pattern
    // ----------------------------------------------------------------
    always_comb begin
        status_d                 = '0;
        status_d.valid           = 1'b1;
        status_d.enabled         = 1'b1;
        status_d.arch_error_code = code_d;
        if (no_action || act_req) begin
            status_d.overflow    = 1'b0;
            status_d.uncorrected = 1'b1;
            status_d.misc_valid  = 1'b1;
            status_d.addr_valid  = 1'b1;
            status_d.ctx_corrupt = 1'b0;
            status_d.signalling  = 1'b1;
            status_d.action_req  = act_req;
        end
        // a second error over a live record marks overflow
        if (status_q.valid)
            status_d.overflow = 1'b1;
    end

    // ----------------------------------------------------------------
    // bank logging
    // ----------------------------------------------------------------
    // whole record lands on one edge so software never sees a torn log
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            status_q <= '0;
        end else if (CE) begin
            if (ERR_VALID)
                status_q <= status_d;
            else if (BANK_CLEAR)
                status_q <= '0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            misc_q <= '{addr_lsb: MISC_LSB_RESET, addr_mode: MISC_MODE_RESET};
            addr_q <= ADDR_RESET;
        end else if (CE && ERR_VALID) begin
            addr_q <= ERR_INFO.phys_addr;
            if (no_action || act_req) begin
                misc_q.addr_mode <= MISC_MODE_PHYS;
                misc_q.addr_lsb  <= ERR_INFO.addr_lsb;
            end else begin
                misc_q <= '{addr_lsb: MISC_LSB_RESET, addr_mode: MISC_MODE_RESET};
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            visible_q <= '0;
        end else if (CE) begin
            if (ERR_VALID)
                visible_q <= BANK_SHARERS;
            else if (BANK_CLEAR)
                visible_q <= '0;
        end
    end

    // ----------------------------------------------------------------
    // global check status and exception broadcast
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            restart_ip_valid_q <= '0;
            error_ip_valid_q <= '0;
            mce_q  <= '0;
        end else if (CE) begin
            if (ERR_VALID && (no_action || act_req) && UCR_SUPPORTED) begin
                mce_q <= '1;
                for (int i = 0; i < NUM_LP; i++) begin
                    if (act_req && ERR_AFFECTED_LP[i]) begin
                        restart_ip_valid_q[i] <= 1'b0;
                        error_ip_valid_q[i] <= (ERR_INFO.kind == EV_DATA_LOAD);
                    end else begin
                        restart_ip_valid_q[i] <= 1'b1;
                        error_ip_valid_q[i] <= 1'b0;
                    end
                end
            end else if (GLOBAL_CLEAR) begin
                restart_ip_valid_q <= '0;
                error_ip_valid_q <= '0;
                mce_q  <= '0;
            end
        end
    end

    assign BANK_STATUS      = status_q;
    assign BANK_MISC        = misc_q;
    assign BANK_ADDR        = addr_q;
    assign BANK_VISIBLE     = visible_q;
    assign RESTART_IP_VALID = restart_ip_valid_q;
    assign ERROR_IP_VALID   = error_ip_valid_q;
    assign CHECK_EXCEPTION  = mce_q;
endmodule

// File: testbench/mcce_chk.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the error logging block
// ----------------------------------------------------------------
module mcce_chk
    import mcce_pkg::*;
#(
    parameter int NUM_LP = 4
)
(
    // clock and reset
    input wire logic                CLK_SYS,
    input wire logic                RST,
    input wire logic                CE,
    // error report
    input wire logic                ERR_VALID,
    input wire mcce_pkg::mcce_err_t ERR_INFO,
    input wire logic [NUM_LP-1:0]   ERR_AFFECTED_LP,
    input wire logic [NUM_LP-1:0]   BANK_SHARERS,
    input wire logic                UCR_SUPPORTED,
    input wire logic                BANK_CLEAR,
    input wire logic                GLOBAL_CLEAR,
    // bank and global status
    input wire mcce_pkg::mcce_status_t BANK_STATUS,
    input wire mcce_pkg::mcce_misc_t   BANK_MISC,
    input wire logic [63:0]         BANK_ADDR,
    input wire logic [NUM_LP-1:0]   BANK_VISIBLE,
    input wire logic [NUM_LP-1:0]   RESTART_IP_VALID,
    input wire logic [NUM_LP-1:0]   ERROR_IP_VALID,
    input wire logic [NUM_LP-1:0]   CHECK_EXCEPTION
);
    wire logic        tk = CE && ERR_VALID;
    wire logic        ao = tk && (ERR_INFO.kind == EV_SCRUB || ERR_INFO.kind == EV_WRITEBACK);
    wire logic        ar = tk && (ERR_INFO.kind == EV_DATA_LOAD || ERR_INFO.kind == EV_INSTR_FETCH);
    wire logic [15:0] code = BANK_STATUS.arch_error_code;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    chk_scrub_code:
    assert property (tk && ERR_INFO.kind == EV_SCRUB |=> code[15:4] == 12'h00C) else $error("scrub code");
    chk_wb_code:
    assert property (tk && ERR_INFO.kind == EV_WRITEBACK |=> code == 16'h017A) else $error("writeback code");
    chk_recoverable_action_required_error_code:
    assert property (ar |=> code == ($past(ERR_INFO.kind) == EV_DATA_LOAD ? 16'h0134 : 16'h0150))
        else $error("action code");
    chk_bus_fields:
    assert property (tk && ERR_INFO.kind == EV_BUS |=> code[15:11] == 5'h01 && code[3:2] != 2'h1)
        else $error("bus code form");
    chk_mem_txn:
    assert property (tk && ERR_INFO.kind == EV_MEMCTL |=> code[15:7] == 9'h001 && code[6:4] < 3'h5)
        else $error("memory code form");
    // overflow masked: a second log onto a full bank may set it
    chk_flag_pattern:
    assert property (ao || ar |=> (BANK_STATUS[24:16] & 9'h17F) == {8'hBD, $past(ar)}) else $error("flags");
    chk_misc_mode:
    assert property (ao |=> BANK_MISC == {$past(ERR_INFO.addr_lsb), 3'h2} && BANK_ADDR == $past(ERR_INFO.phys_addr))
        else $error("misc or addr");
    chk_bank_share:
    assert property (tk |=> BANK_VISIBLE == $past(BANK_SHARERS)) else $error("visibility");
    chk_exc_bcast:
    assert property ((ao || ar) && UCR_SUPPORTED |=> &CHECK_EXCEPTION) else $error("broadcast");
    chk_ao_global:
    assert property (ao && UCR_SUPPORTED |=> &RESTART_IP_VALID && ERROR_IP_VALID == '0) else $error("ao global");
    chk_ar_restart:
    assert property (ar && UCR_SUPPORTED |=> RESTART_IP_VALID == ~$past(ERR_AFFECTED_LP)) else $error("ar restart");
    chk_filter_clear:
    assert property (ao || ar |=> !code[FILTER_BIT_POS]) else $error("filter bit");
endmodule

bind mcce_top mcce_chk #(.NUM_LP(NUM_LP)) u_mcce_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .ERR_VALID(ERR_VALID), .ERR_INFO(ERR_INFO),
    .ERR_AFFECTED_LP(ERR_AFFECTED_LP), .BANK_SHARERS(BANK_SHARERS), .UCR_SUPPORTED(UCR_SUPPORTED),
    .BANK_CLEAR(BANK_CLEAR), .GLOBAL_CLEAR(GLOBAL_CLEAR), .BANK_STATUS(BANK_STATUS), .BANK_MISC(BANK_MISC),
    .BANK_ADDR(BANK_ADDR), .BANK_VISIBLE(BANK_VISIBLE), .RESTART_IP_VALID(RESTART_IP_VALID),
    .ERROR_IP_VALID(ERROR_IP_VALID), .CHECK_EXCEPTION(CHECK_EXCEPTION));

// File: testbench/test_mcce_top.sv
`timescale 1ns/1ps
module test_mcce_top;
    import mcce_pkg::*;
    logic         CLK_SYS = 0;
    logic         RST = 1;
    logic         CE = 1;
    logic         ERR_VALID = 0;
    mcce_err_t    ERR_INFO = '0;
    logic [3:0]   ERR_AFFECTED_LP = '0;
    logic [3:0]   BANK_SHARERS = 4'h3;
    logic         UCR_SUPPORTED = 1;
    logic         BANK_CLEAR = 0;
    logic         GLOBAL_CLEAR = 0;
    mcce_status_t BANK_STATUS;
    mcce_misc_t   BANK_MISC;
    logic [63:0]  BANK_ADDR;
    logic [3:0]   BANK_VISIBLE, RESTART_IP_VALID, ERROR_IP_VALID, CHECK_EXCEPTION;
    int           err_count = 0;
    int           n_checks = 0;
    mcce_err_t    e;
    logic [1:0]   sp;
    logic [3:0]   ch;
    logic [3:0]   RQ [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h0, 4'h0};
    mcce_action_t AC [9] = '{ACT_UNKNOWN, ACT_READ, ACT_WRITE, ACT_READ, ACT_WRITE, ACT_READ,
                             ACT_PREFETCH, ACT_EVICT, ACT_SNOOP};

    mcce_top #(.NUM_LP(4)) u_mcce_top (
        .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .ERR_VALID(ERR_VALID), .ERR_INFO(ERR_INFO),
        .ERR_AFFECTED_LP(ERR_AFFECTED_LP), .BANK_SHARERS(BANK_SHARERS), .UCR_SUPPORTED(UCR_SUPPORTED),
        .BANK_CLEAR(BANK_CLEAR), .GLOBAL_CLEAR(GLOBAL_CLEAR), .BANK_STATUS(BANK_STATUS), .BANK_MISC(BANK_MISC),
        .BANK_ADDR(BANK_ADDR), .BANK_VISIBLE(BANK_VISIBLE), .RESTART_IP_VALID(RESTART_IP_VALID),
        .ERROR_IP_VALID(ERROR_IP_VALID), .CHECK_EXCEPTION(CHECK_EXCEPTION));

    initial begin
        forever #50 CLK_SYS = ~CLK_SYS;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // called at a falling edge; a clear cycle first keeps records apart
    task automatic fire(input mcce_err_t x, input logic clr);
        if (clr) begin
            BANK_CLEAR = 1;
            GLOBAL_CLEAR = 1;
            @(negedge CLK_SYS);
            BANK_CLEAR = 0;
            GLOBAL_CLEAR = 0;
        end
        ERR_INFO = x;
        ERR_VALID = 1;
        @(negedge CLK_SYS);
        ERR_VALID = 0;
    endtask

    task automatic glob(input logic [3:0] r, input logic [3:0] ei, input logic [3:0] x);
        chk(RESTART_IP_VALID, r, "restart ip valid");
        chk(ERROR_IP_VALID, ei, "error ip valid");
        chk(CHECK_EXCEPTION, x, "check exception");
    endtask

    initial begin
        repeat (20000) @(posedge CLK_SYS);
        err_count++;
        conclude;
    end

    initial begin
        repeat (2) @(negedge CLK_SYS);
        RST = 0;
        chk({BANK_STATUS, RESTART_IP_VALID, CHECK_EXCEPTION}, '0, "reset state");
        // bus codes across the whole request table
        for (int i = 0; i < 9; i++) begin
            e = '0;
            e.kind = EV_BUS;
            e.action = AC[i];
            e.src_known = (i > 2 && i < 6);
            e.is_instr = (i == 5);
            e.level = 2'(i);
            e.participation = 2'(i + 1);
            e.timed_out = i[0];
            e.space = (i == 7) ? 2'h1 : (i % 3 == 0) ? 2'h0 : (i % 3 == 1) ? 2'h2 : 2'h3;
            sp = (e.space == 2'h1) ? 2'h3 : e.space;
            fire(e, 0);
            chk(BANK_STATUS.arch_error_code, {1'b1, e.participation, e.timed_out, RQ[i], sp, e.level},
                "bus code");
        end
        // eviction and snoop are legal on cache errors
        for (int j = 0; j < 2; j++) begin
            e = '0;
            e.kind = EV_CACHE;
            e.action = j ? ACT_SNOOP : ACT_EVICT;
            fire(e, 0);
            chk(BANK_STATUS.arch_error_code[8:4], j ? 5'h18 : 5'h17, "cache request");
        end
        // memory controller transactions and channels
        for (int t = 0; t < 6; t++) begin
            e = '0;
            e.kind = EV_MEMCTL;
            e.mem_txn = 3'(t);
            e.channel = 4'(t * 3);
            e.chan_valid = (t != 4);
            ch = (t == 4) ? 4'hF : e.channel;
            fire(e, 0);
            chk(BANK_STATUS.arch_error_code, {8'h01, (t > 4) ? 3'h0 : 3'(t), ch}, "memory code");
        end
        // overflow on a second record; error wins over a same-cycle clear
        fire(e, 1);
        chk(BANK_STATUS[24:23], 2'b10, "first record");
        BANK_CLEAR = 1;
        fire(e, 0);
        BANK_CLEAR = 0;
        chk(BANK_STATUS[24:23], 2'b11, "overflow or clear won");
        // no-action records: scrub on channel 14, scrub unspecified, writeback
        for (int k = 0; k < 3; k++) begin
            e = '0;
            e.kind = (k == 2) ? EV_WRITEBACK : EV_SCRUB;
            e.channel = 4'hE;
            e.chan_valid = (k == 0);
            e.phys_addr = 64'h0000_00AB_CDEF_1000 + 64'(k);
            e.addr_lsb = 6'h0C;
            fire(e, 1);
            chk(BANK_STATUS.arch_error_code, (k == 2) ? 16'h017A : (k ? 16'h00CF : 16'h00CE),
                "no-action code");
            chk(BANK_STATUS[24:16], 9'h17A, "no-action flags");
            chk(BANK_MISC, {6'h0C, 3'h2}, "misc mode and lsb");
            chk(BANK_ADDR, e.phys_addr, "fault address");
            chk(BANK_VISIBLE, 4'h3, "sharers");
            glob(4'hF, 4'h0, 4'hF);
        end
        // action-required records on another set of sharers
        BANK_SHARERS = 4'hC;
        for (int k = 0; k < 2; k++) begin
            e = '0;
            e.kind = k ? EV_INSTR_FETCH : EV_DATA_LOAD;
            ERR_AFFECTED_LP = k ? 4'h4 : 4'h2;
            fire(e, 1);
            chk(BANK_STATUS.arch_error_code, k ? 16'h0150 : 16'h0134, "action code");
            chk(BANK_STATUS[24:16], 9'h17B, "action flags");
            chk(BANK_VISIBLE, 4'hC, "sharers");
            glob(~ERR_AFFECTED_LP, k ? 4'h0 : 4'h2, 4'hF);
        end
        // without recoverable support the global status stays clear
        UCR_SUPPORTED = 0;
        fire(e, 1);
        glob(4'h0, 4'h0, 4'h0);
        UCR_SUPPORTED = 1;
        // a held clock enable ignores a report
        BANK_CLEAR = 1;
        @(negedge CLK_SYS);
        BANK_CLEAR = 0;
        CE = 0;
        fire(e, 0);
        CE = 1;
        chk({BANK_STATUS.valid, BANK_VISIBLE}, '0, "frozen by enable");
        // a reset in mid-run drops a live record and the global status
        fire(e, 1);
        RST = 1;
        @(negedge CLK_SYS);
        RST = 0;
        chk({BANK_STATUS, BANK_MISC, BANK_VISIBLE, RESTART_IP_VALID, ERROR_IP_VALID, CHECK_EXCEPTION}, '0,
            "mid-run reset");
        chk(BANK_ADDR, '0, "mid-run reset address");
        conclude;
    end
endmodule
